// file: src/conv_control.v
// converter control: registers, clock select, pin decode, triggers
// assumes a single-cycle register port on core_clk; pins are async
//
// Notes on behaviour
// - justify bit picks right or left alignment
// - halve bit divides system-derived conversion clock
// - config code sets analog or digital inputs
// - some codes take references from inputs three/two
// - two bit periods of recovery after conversion
// - rc clock waits one instruction cycle first
// - completion clears go and loads result
// - rc conversion in sleep may wake device
// - non-rc sleep aborts, converter on stays set
// - reset disables converter, all pins analog
// - result registers are not reset
// - special trigger starts conversion, clears timer
// - trigger with converter off only clears timer
// - result readable as high and low bytes
`default_nettype none
`include "conv_ctrl_regs.vh"
module conv_control
(
	input wire core_clk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire sleep_req,
	input wire special_trigger,
	input wire [9:0] sample_in,
	output wire converter_powered,
	output wire hold_connected,
	output wire [2:0] channel_sel,
	output reg [4:0] analog_pins,
	output reg vref_pos_ext,
	output reg vref_neg_ext,
	output wire irq,
	output wire wake_req
);
	//------------------------------------------------
	// registers
	//------------------------------------------------
	reg [7:0] ctrl0_q;
	reg [7:0] ctrl1_q;
	reg flag_q;
	reg irq_en_q;
	reg [3:0] capcomp_q;
	reg [15:0] timer_q;
	reg [7:0] rhi_q;
	reg [7:0] rlo_q;
	reg trig_s1_q;
	reg trig_s2_q;
	reg trig_prev_q;
	reg sleep_s1_q;
	reg sleep_s2_q;
	reg [7:0] div_q;
	reg half_q;
	wire [9:0] result;
	wire done_pulse;
	wire busy;

	//------------------------------------------------
	// write decode
	//------------------------------------------------
	function wr_hit;
		input [7:0] addr;
		input [7:0] target;
		input strobe;
		begin
			wr_hit = strobe && (addr == target);
		end
	endfunction
	wire wr_ctrl0 = wr_hit(reg_addr, `ADDR_CTRL0, reg_wr);
	wire wr_ctrl1 = wr_hit(reg_addr, `ADDR_CTRL1, reg_wr);
	wire wr_flags = wr_hit(reg_addr, `ADDR_FLAGS, reg_wr);
	wire wr_enables = wr_hit(reg_addr, `ADDR_ENABLES, reg_wr);
	wire wr_capcomp = wr_hit(reg_addr, `ADDR_CAPCOMP, reg_wr);
	wire wr_res_hi = wr_hit(reg_addr, `ADDR_RES_HI, reg_wr);
	wire wr_res_lo = wr_hit(reg_addr, `ADDR_RES_LO, reg_wr);
	wire [1:0] clk_sel = ctrl0_q[`CLK_SEL_MSB:`CLK_SEL_LSB];
	wire rc_clock = (clk_sel == `CLK_SEL_RC);
	wire on = ctrl0_q[`CTRL0_ON_BIT];
	wire [3:0] pcfg = ctrl1_q[`PCFG_MSB:0];
	// idle only while the hold capacitor is connected: a start taken
	// in the recovery gap would be lost and leave go stuck high
	wire seq_idle = hold_connected;
	wire trig_edge = trig_s2_q & ~trig_prev_q;
	wire trig_hit = trig_edge && (capcomp_q == `CAPCOMP_SPECIAL);
	wire trig_start = trig_hit && on && seq_idle;
	wire sw_go = wr_ctrl0 && reg_wdata[`CTRL0_GO_BIT] &&
		reg_wdata[`CTRL0_ON_BIT] && seq_idle;
	wire start = sw_go || trig_start;
	// in sleep without rc clock the converter is shut down
	wire sleep_abort = sleep_s2_q && !rc_clock;
	assign converter_powered = on && !sleep_abort;
	assign channel_sel = ctrl0_q[`CHAN_MSB:`CHAN_LSB];
	assign irq = flag_q & irq_en_q;
	assign wake_req = sleep_s2_q & irq;

	//------------------------------------------------
	// conversion clock divider
	//------------------------------------------------
	// divider reload depends on selection; rc approximated by fixed count
	function [7:0] div_for;
		input [1:0] sel;
		begin
			case (sel)
			2'h0: div_for = `DIV_SEL0;
			2'h1: div_for = `DIV_SEL1;
			2'h2: div_for = `DIV_SEL2;
			default: div_for = `RC_DIV;
			endcase
		end
	endfunction
	wire raw_tick = (div_q == 8'h01);
	// halving only applies to system-derived sources
	wire halve = ctrl1_q[`CTRL1_HALVE_BIT] && !rc_clock;
	wire bit_tick = raw_tick && (!halve || half_q);
	reg [7:0] idiv_q;
	wire instr_tick = (idiv_q == 8'h01);
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_q <= 8'h01;
			half_q <= 1'b0;
			idiv_q <= 8'h01;
		end
		else
		begin
			div_q <= raw_tick ? div_for(clk_sel) : div_q - 8'h01;
			if (raw_tick)
				half_q <= ~half_q;
			idiv_q <= instr_tick ? `INSTR_DIV : idiv_q - 8'h01;
		end
	end

	//------------------------------------------------
	// pin synchronisers
	//------------------------------------------------
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
			trig_prev_q <= 1'b0;
			sleep_s1_q <= 1'b0;
			sleep_s2_q <= 1'b0;
		end
		else
		begin
			trig_s1_q <= special_trigger;
			trig_s2_q <= trig_s1_q;
			trig_prev_q <= trig_s2_q;
			sleep_s1_q <= sleep_req;
			sleep_s2_q <= sleep_s1_q;
		end
	end

	//------------------------------------------------
	// sequencer
	//------------------------------------------------
	conv_sequencer u_seq
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.bit_tick(bit_tick),
		.instr_tick(instr_tick),
		.start(start),
		.abort(sleep_abort || !on),
		.rc_clock(rc_clock),
		.sample_in(sample_in),
		.busy(busy),
		.hold_connected(hold_connected),
		.done_pulse(done_pulse),
		.result(result)
	);

	//------------------------------------------------
	// control registers
	//------------------------------------------------
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl0_q <= `CTRL0_RESET;
		else if (wr_ctrl0)
		begin
			ctrl0_q <= reg_wdata & `CTRL0_MASK;
			// go reads set only for a start taken or one still running
			ctrl0_q[`CTRL0_GO_BIT] <= sw_go ||
				(busy && reg_wdata[`CTRL0_ON_BIT]);
		end
		else if (done_pulse)
			ctrl0_q[`CTRL0_GO_BIT] <= 1'b0;
		else if (sleep_abort || !on)
			ctrl0_q[`CTRL0_GO_BIT] <= 1'b0;
		else if (trig_start)
			ctrl0_q[`CTRL0_GO_BIT] <= 1'b1;
	end

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl1_q <= `CTRL1_RESET;
		else if (wr_ctrl1)
			ctrl1_q <= reg_wdata & `CTRL1_MASK;
	end

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_en_q <= 1'b0;
			capcomp_q <= 4'h0;
		end
		else
		begin
			if (wr_enables)
				irq_en_q <= reg_wdata[`FLAG_BIT];
			if (wr_capcomp)
				capcomp_q <= reg_wdata[`CAPCOMP_MSB:0];
		end
	end

	// set wins over a software clear in the same cycle
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			flag_q <= 1'b0;
		else if (done_pulse)
			flag_q <= 1'b1;
		else if (wr_flags)
			flag_q <= reg_wdata[`FLAG_BIT];
	end

	//------------------------------------------------
	// sixteen bit timer
	//------------------------------------------------
	// counts instruction cycles; the trigger clears it even with the
	// converter off
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			timer_q <= 16'h0000;
		else if (trig_hit)
			timer_q <= 16'h0000;
		else if (instr_tick)
			timer_q <= timer_q + 16'h0001;
	end

	//------------------------------------------------
	// result registers, not reset
	//------------------------------------------------
	// no reset term: power-up contents stay unknown
	always @(posedge core_clk)
	begin
		if (done_pulse)
		begin
			if (ctrl1_q[`CTRL1_JUST_BIT])
			begin
				rhi_q <= {6'h00, result[9:8]};
				rlo_q <= result[7:0];
			end
			else
			begin
				rhi_q <= result[9:2];
				rlo_q <= {result[1:0], 6'h00};
			end
		end
		else if (wr_res_hi)
			rhi_q <= reg_wdata;
		else if (wr_res_lo)
			rlo_q <= reg_wdata;
	end

	//------------------------------------------------
	// pin configuration decode
	//------------------------------------------------
	always @*
	begin
		vref_pos_ext = 1'b0;
		vref_neg_ext = 1'b0;
		case (pcfg)
		4'h0, 4'h2, 4'h9: analog_pins = 5'h1f;
		4'h1, 4'h3, 4'ha:
		begin
			analog_pins = 5'h17;
			vref_pos_ext = 1'b1;
		end
		4'h4: analog_pins = 5'h0b;
		4'h5:
		begin
			analog_pins = 5'h03;
			vref_pos_ext = 1'b1;
		end
		4'h6, 4'h7: analog_pins = 5'h00;
		4'h8, 4'hb, 4'hc:
		begin
			analog_pins = 5'h13;
			vref_pos_ext = 1'b1;
			vref_neg_ext = 1'b1;
		end
		4'hd:
		begin
			analog_pins = 5'h03;
			vref_pos_ext = 1'b1;
			vref_neg_ext = 1'b1;
		end
		4'he: analog_pins = 5'h01;
		default:
		begin
			analog_pins = 5'h01;
			vref_pos_ext = 1'b1;
			vref_neg_ext = 1'b1;
		end
		endcase
	end

	//------------------------------------------------
	// read port
	//------------------------------------------------
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
			`ADDR_CTRL0: reg_rdata <= ctrl0_q;
			`ADDR_CTRL1: reg_rdata <= ctrl1_q;
			`ADDR_RES_HI: reg_rdata <= rhi_q;
			`ADDR_RES_LO: reg_rdata <= rlo_q;
			`ADDR_FLAGS: reg_rdata <= {1'b0, flag_q, 6'h00};
			`ADDR_ENABLES: reg_rdata <= {1'b0, irq_en_q, 6'h00};
			`ADDR_CAPCOMP: reg_rdata <= {4'h0, capcomp_q};
			`ADDR_TIMER_LO: reg_rdata <= timer_q[7:0];
			`ADDR_TIMER_HI: reg_rdata <= timer_q[15:8];
			default: reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end
endmodule // conv_control
`default_nettype wire

// file: src/conv_ctrl_regs.vh
// register map, field positions, reset values and timing counts for the
// converter control block; included by the control and sequencer modules
`ifndef CONV_CTRL_REGS_VH
`define CONV_CTRL_REGS_VH
`define ADDR_FLAGS 8'h0c
`define ADDR_RES_HI 8'h1e
`define ADDR_CTRL0 8'h1f
`define ADDR_ENABLES 8'h8c
`define ADDR_RES_LO 8'h9e
`define ADDR_CTRL1 8'h9f
`define ADDR_TIMER_LO 8'h0e
`define ADDR_TIMER_HI 8'h0f
`define ADDR_CAPCOMP 8'h17
`define CTRL0_RESET 8'h00
`define CTRL1_RESET 8'h00
`define CTRL0_MASK 8'hfd
`define CTRL1_MASK 8'hcf
`define FLAG_BIT 6
`define CTRL0_ON_BIT 0
`define CTRL0_GO_BIT 2
`define CTRL1_JUST_BIT 7
`define CTRL1_HALVE_BIT 6
`define CLK_SEL_RC 2'h3
`define CAPCOMP_SPECIAL 4'hb
`define RECOVERY_PERIODS 4'h2
`define CONV_PERIODS 4'hb
`define INSTR_DIV 8'h04
`define RC_DIV 8'h0c
`define DIV_SEL0 8'h02
`define DIV_SEL1 8'h08
`define DIV_SEL2 8'h20
`define CLK_SEL_MSB 7
`define CLK_SEL_LSB 6
`define CHAN_MSB 5
`define CHAN_LSB 3
`define PCFG_MSB 3
`define CAPCOMP_MSB 3
`endif

// file: src/conv_sequencer.v
// conversion sequencer: start delay, bit periods, recovery gap
// assumes one-cycle enables for bit period and instruction cycle
`default_nettype none
`include "conv_ctrl_regs.vh"
module conv_sequencer
(
	input wire core_clk,
	input wire rst_n,
	input wire bit_tick,
	input wire instr_tick,
	input wire start,
	input wire abort,
	input wire rc_clock,
	input wire [9:0] sample_in,
	output wire busy,
	output reg hold_connected,
	output reg done_pulse,
	output reg [9:0] result
);
	localparam S_IDLE = 2'd0;
	localparam S_WAIT = 2'd1;
	localparam S_CONV = 2'd2;
	localparam S_RECOVER = 2'd3;
	reg [1:0] state_q;
	reg [3:0] count_q;
	assign busy = (state_q == S_WAIT) || (state_q == S_CONV);
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= S_IDLE;
			count_q <= 4'h0;
			hold_connected <= 1'b1;
			done_pulse <= 1'b0;
			result <= 10'h000;
		end
		else
		begin
			done_pulse <= 1'b0;
			if (abort)
			begin
				state_q <= S_IDLE;
				hold_connected <= 1'b1;
			end
			else
			begin
				case (state_q)
				S_IDLE:
				begin
					if (start)
					begin
						state_q <= rc_clock ? S_WAIT : S_CONV;
						count_q <= 4'h0;
						hold_connected <= 1'b0;
					end
				end
				S_WAIT:
				begin
					// rc source: one instruction cycle before starting
					if (instr_tick)
						state_q <= S_CONV;
				end
				S_CONV:
				begin
					if (bit_tick)
					begin
						if (count_q == `CONV_PERIODS - 4'h1)
						begin
							state_q <= S_RECOVER;
							count_q <= 4'h0;
							result <= sample_in;
							done_pulse <= 1'b1;
						end
						else
							count_q <= count_q + 4'h1;
					end
				end
				S_RECOVER:
				begin
					if (bit_tick)
					begin
						if (count_q == `RECOVERY_PERIODS - 4'h1)
						begin
							state_q <= S_IDLE;
							hold_connected <= 1'b1;
						end
						else
							count_q <= count_q + 4'h1;
					end
				end
				default:
					state_q <= S_IDLE;
				endcase
			end
		end
	end
endmodule // conv_sequencer
`default_nettype wire

// file: testbench/analog_source.sv
// far side model: analog level on the input and the trigger line
// assumes the bench sets level and raises fire for one cycle
`default_nettype none
module analog_source
(
	input wire logic core_clk,
	input wire logic fire,
	input wire logic [9:0] level,
	output logic [9:0] sample_in,
	output logic special_trigger
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	assign sample_in = level;
	// wide pulse: the two sync flops must not miss it
	always @(posedge core_clk)
	begin
		if (fire)
			n <= 6;
		else if (n > 0)
			n <= n - 1;
	end
	assign special_trigger = n > 0;
endmodule // analog_source
`default_nettype wire

// file: testbench/conv_control_props.sv
// assertions on the converter control ports
// assumes one clock, active low reset, map from the shared header
`default_nettype none
`include "conv_ctrl_regs.vh"
module conv_control_props
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic sleep_req,
	input wire logic converter_powered,
	input wire logic [4:0] analog_pins,
	input wire logic vref_pos_ext,
	input wire logic vref_neg_ext,
	input wire logic irq,
	input wire logic wake_req
);
	localparam logic [15:0] pos_map = 16'hbd2a;
	localparam logic [15:0] neg_map = 16'hb900;
	wire w1 = reg_wr && reg_addr == `ADDR_CTRL1;
	wire w0 = reg_wr && reg_addr == `ADDR_CTRL0;
	wire pos_w = pos_map[reg_wdata[3:0]];
	wire neg_w = neg_map[reg_wdata[3:0]];
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	property p_unmapped;
		reg_rd && reg_addr == 8'h01 |=> reg_rdata == 8'h00;
	endproperty
	property p_digital;
		w1 && reg_wdata[3:1] == 3'b011 |=> analog_pins == 5'h00;
	endproperty
	property p_one;
		w1 && reg_wdata[3:0] == 4'he |=> analog_pins == 5'h01;
	endproperty
	property p_refs;
		w1 |=> vref_pos_ext == $past(pos_w) && vref_neg_ext == $past(neg_w);
	endproperty
	property p_reset;
		$rose(rst_n) |-> analog_pins == 5'h1f && !converter_powered && !irq;
	endproperty
	property p_off;
		w0 && !reg_wdata[0] |=> !converter_powered;
	endproperty
	sequence s_sleep;
		w0 && reg_wdata[7:6] != 2'h3 ##1 sleep_req [*4];
	endsequence
	property p_sleep;
		s_sleep |-> !converter_powered;
	endproperty
	property p_wake;
		sleep_req [*3] ##0 irq |-> wake_req;
	endproperty
	property p_mask;
		reg_wr && reg_addr == `ADDR_ENABLES && !reg_wdata[6] |=> !irq;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
	a_unmapped: assert property (p_unmapped) else $error("hole read");
	a_digital: assert property (p_digital) else $error("pins digital");
	a_one: assert property (p_one) else $error("pins code e");
	a_refs: assert property (p_refs) else $error("reference pick");
	a_reset: assert property (p_reset) else $error("reset state");
	a_off: assert property (p_off) else $error("still powered");
	a_sleep: assert property (p_sleep) else $error("sleep power");
	a_wake: assert property (p_wake) else $error("wake no irq");
	a_mask: assert property (p_mask) else $error("masked irq");
	c_irq: cover property ($rose(irq));
	c_wake: cover property ($rose(wake_req));
	c_down: cover property ($fell(converter_powered));
endmodule // conv_control_props
bind conv_control conv_control_props u_props (.core_clk, .rst_n,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_req,
	.converter_powered, .analog_pins, .vref_pos_ext, .vref_neg_ext,
	.irq, .wake_req);
`default_nettype wire

// file: testbench/conv_control_test.sv
// self-checking bench for conv_control with the analog source model
// assumes the checker is bound from its own file
`default_nettype none
`include "conv_ctrl_regs.vh"
module conv_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
	logic sleep_req = 0, fire = 0, jus = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
	logic [9:0] level = 10'h000;
	wire [7:0] reg_rdata;
	wire [9:0] sample_in;
	wire special_trigger, converter_powered, hold_connected, irq;
	wire wake_req, vref_pos_ext, vref_neg_ext;
	wire [2:0] channel_sel;
	wire [4:0] analog_pins;
	int fail_count = 0, num_checks = 0, c, j, k, s, n, p;
	logic [7:0] q[$];
	logic [7:0] ra[5] = '{`ADDR_FLAGS, `ADDR_CTRL0, `ADDR_ENABLES,
		`ADDR_CTRL1, 8'h01};
	always #5 core_clk = ~core_clk;
	conv_control DUT (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .sleep_req, .special_trigger, .sample_in,
		.converter_powered, .hold_connected, .channel_sel, .analog_pins,
		.vref_pos_ext, .vref_neg_ext, .irq, .wake_req);
	analog_source far (.core_clk, .fire, .level, .sample_in,
		.special_trigger);
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	// polls go; a lost conversion ends the run
	task automatic wait_go(input logic v);
		for (k = 0; k < 200; k++)
		begin
			rd(`ADDR_CTRL0);
			if (d[`CTRL0_GO_BIT] === v)
				break;
		end
		if (k == 200)
		begin
			fail_count++;
			summarize();
		end
	endtask
	// counts cycles until the hold capacitor is back; bounded
	task automatic wait_hold();
		for (n = 1; n < 400; n++)
		begin
			@(posedge core_clk);
			#1;
			if (hold_connected === 1'b1)
				break;
		end
		if (n == 400)
		begin
			fail_count++;
			summarize();
		end
	endtask
	task automatic results();
		s = level;
		q.push_back(8'(jus ? s >> 8 : s >> 2));
		q.push_back(8'(jus ? s & 255 : (s & 3) << 6));
		rd(`ADDR_RES_HI);
		chk(d, q.pop_front());
		rd(`ADDR_RES_LO);
		chk(d, q.pop_front());
	endtask
	task automatic conv(input logic [7:0] c0);
		wr(`ADDR_CTRL0, c0);
		#1 chk({5'b0, channel_sel}, {5'b0, c0[5:3]});
		@(posedge core_clk);
		level <= 10'($urandom);
		repeat (4) @(posedge core_clk);
		wait_hold();
		wr(`ADDR_CTRL0, c0 | 8'h04);
	endtask
	initial
	begin
		void'($urandom(32'h8f00));
		repeat (3) @(posedge core_clk);
		rst_n <= 1;
		foreach (ra[i])
		begin
			rd(ra[i]);
			chk(d, 8'h00);
		end
		chk({3'b0, analog_pins}, 8'h1f);
		$display("test reset done");
		for (c = 0; c < 16; c++)
		begin
			wr(`ADDR_CTRL1, 8'(c));
			#1 chk({7'b0, vref_pos_ext}, 8'(16'hbd2a >> c & 1));
			chk({7'b0, vref_neg_ext}, 8'(16'hb900 >> c & 1));
			if (c < 3 && c != 1 || c == 9)
				chk({3'b0, analog_pins}, 8'h1f);
			if (c == 6 || c == 7 || c == 14)
				chk({3'b0, analog_pins}, 8'(c / 14));
		end
		$display("test pins done");
		wr(`ADDR_ENABLES, 8'h40);
		// j bit 0 picks justify, bit 1 the rc clock
		for (j = 0; j < 4; j++)
		begin
			jus = j[0];
			wr(`ADDR_CTRL1, {j[0], j[0], 6'h00});
			// p: bit period in clocks, halving ignored on the rc clock
			p = j[1] ? 12 : (j[0] ? 4 : 2);
			conv({j[1] ? 2'h3 : 2'h0, 3'(j + 2), 3'h1});
			wait_hold();
			chk(8'(n > 12 * p && n <= 13 * p + 4), 8'h01);
			wait_go(0);
			results();
			chk({7'b0, irq}, 8'h01);
			rd(`ADDR_FLAGS);
			chk(d & 8'h40, 8'h40);
			wr(`ADDR_FLAGS, 8'h00);
		end
		$display("test conversions done");
		conv(8'hc1);
		sleep_req <= 1;
		wait_go(0);
		chk({7'b0, wake_req}, 8'h01);
		@(posedge core_clk);
		sleep_req <= 0;
		results();
		$display("test rc sleep done");
		wr(`ADDR_CAPCOMP, 8'h0b);
		wr(`ADDR_CTRL0, 8'h00);
		repeat (1100) @(posedge core_clk);
		fire <= 1;
		@(posedge core_clk);
		fire <= 0;
		repeat (10) @(posedge core_clk);
		rd(`ADDR_TIMER_HI);
		chk(d, 8'h00);
		rd(`ADDR_CTRL0);
		chk(d, 8'h00);
		wr(`ADDR_CTRL0, 8'h01);
		level <= 10'($urandom);
		repeat (1100) @(posedge core_clk);
		fire <= 1;
		@(posedge core_clk);
		fire <= 0;
		wait_go(1);
		rd(`ADDR_TIMER_HI);
		chk(d, 8'h00);
		wait_go(0);
		results();
		$display("test trigger done");
		wait_hold();
		wr(`ADDR_CTRL0, 8'h05);
		sleep_req <= 1;
		repeat (6) @(posedge core_clk);
		#1 chk({7'b0, converter_powered}, 8'h00);
		rd(`ADDR_CTRL0);
		chk(d & 8'h01, 8'h01);
		@(posedge core_clk);
		sleep_req <= 0;
		wr(`ADDR_ENABLES, 8'h00);
		$display("test sleep abort done");
		rd(`ADDR_RES_HI);
		c = d;
		@(posedge core_clk);
		rst_n <= 0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1;
		rd(`ADDR_RES_HI);
		chk(d, 8'(c));
		rd(`ADDR_CTRL0);
		chk(d, 8'h00);
		$display("test second reset done");
		summarize();
	end
endmodule // conv_control_test
`default_nettype wire
